//--- verilog/eac_pkg.sv
// Constants, types and register map shared by the enclave access checker.
package eac_pkg;
    // Widths.
    localparam int AW = 32;
    localparam int PG_LSB = 12;
    localparam int PW = AW - PG_LSB;
    localparam int SEL_W = 16;
    localparam int PAGES = 16;
    localparam int IDX_W = 4;
    localparam int EC_W = 16;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    // Register byte offsets.
    localparam logic [BUS_AW-1:0] REG_RANGE_BASE = 8'h00;
    localparam logic [BUS_AW-1:0] REG_RANGE_LIMIT = 8'h04;
    localparam logic [BUS_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [BUS_AW-1:0] REG_LAST_CODE = 8'h0c;
    localparam logic [BUS_AW-1:0] REG_CTRL_PA = 8'h10;
    // Status register fields.
    localparam int STAT_ENC_BIT = 0;
    localparam int STAT_PAV_BIT = 1;
    localparam int STAT_GP_BIT = 2;
    localparam int STAT_PF_BIT = 3;
    // Reset values.
    localparam logic [AW-1:0] RANGE_BASE_RST = 32'h0000_0000;
    localparam logic [AW-1:0] RANGE_LIMIT_RST = 32'h0000_0000;
    // Fault error code fields.
    localparam int EC_PRESENT_BIT = 0;
    localparam int EC_WRITE_BIT = 1;
    localparam int EC_FETCH_BIT = 4;
    localparam int EC_ENCL_BIT = 15;
    localparam logic [EC_W-1:0] GP_CODE = 16'h0000;
    // Permission and page state bit positions.
    localparam int PERM_R = 0;
    localparam int PERM_W = 1;
    localparam int PERM_X = 2;
    localparam int ST_BLOCKED = 0;
    localparam int ST_PENDING = 1;
    localparam int ST_MODIFIED = 2;
    // Operand column one maps to the second general register.
    localparam logic [1:0] OPREG_FIRST = 2'h1;
    // Leaf operations seen by the checker.
    typedef enum logic [2:0] {
        LEAF_NONE = 3'b000, LEAF_ENTER = 3'b001, LEAF_RESUME = 3'b010, LEAF_EXIT = 3'b011,
        LEAF_ASYNC_EXIT = 3'b100, LEAF_ADD = 3'b101, LEAF_AUGMENT = 3'b110,
        LEAF_REMOVE = 3'b111
    } eac_leaf_e;
    // Access kinds.
    typedef enum logic [1:0] {
        ACC_READ = 2'b00, ACC_WRITE = 2'b01, ACC_FETCH = 2'b10
    } eac_acc_e;
    // Page types.
    typedef enum logic [2:0] {
        PT_REGULAR = 3'b000, PT_CONTROL = 3'b001, PT_THREAD = 3'b010,
        PT_VERSION = 3'b011, PT_TRIMMED = 3'b100
    } eac_ptype_e;
endpackage : eac_pkg

//--- verilog/eac_owner_mem.sv
// Per-page cache of the owning control structure physical page.
`timescale 1ns/1ps
module eac_owner_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Write port
    input wire logic wrEn,
    input wire logic [eac_pkg::IDX_W-1:0] wrIdx,
    input wire logic wrValid,
    input wire logic [eac_pkg::PW-1:0] wrPa,
    // Read port, data one cycle later
    input wire logic [eac_pkg::IDX_W-1:0] rdIdx,
    output wire logic rdValid,
    output wire logic [eac_pkg::PW-1:0] rdPa
);
    import eac_pkg::*;

    typedef struct packed {
        logic [PAGES-1:0] valid;
        logic [PAGES-1:0][PW-1:0] pa;
        logic rdValid;
        logic [PW-1:0] rdPa;
    } eac_mem_s;

    eac_mem_s st;
    eac_mem_s next_st;

    // Read sees the old entry when a write hits the same index.
    always_comb begin
        next_st = st;
        next_st.rdValid = st.valid[rdIdx];
        next_st.rdPa = st.pa[rdIdx];
        if (wrEn) begin
            next_st.valid[wrIdx] = wrValid;
            next_st.pa[wrIdx] = wrPa;
        end
    end

    // Reset drops every binding so no stale owner can match.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdValid = st.rdValid;
    assign rdPa = st.rdPa;
endmodule : eac_owner_mem

//--- verilog/enclave_access_checker.sv
// Enclave access checker: classifies accesses, checks them, tracks entry and exit.
`timescale 1ns/1ps
//
// Summary of operation
// R1: Enter only by enter/resume, leave by exit/async.
// R2: Enclave range accesses are direct; leaf ones indirect.
// R3: Enclave fetch outside range gives GP, code 0.
// R4: Wrong recorded linear page gives enclave page fault.
// R5: Direct accesses checked against attribute map entry.
// R6: Target page must belong to current enclave.
// R7: Write, read, fetch need map write, read, execute.
// R8: Control, thread, version, trimmed page types fault.
// R9: Blocked, pending or modified pages fault.
// R10: Normal segmentation faults apply unchanged.
// R11: Entry needs zero base on usable segments.
// R12: Entry saves outside thread segments, loads new.
// R13: Exits restore thread segments held at entry.
// R14: Async exit stores segments; resume reloads them.
// R15: Straddling data access split, parts judged apart.
// R16: Straddling fetch faults GP for outside part.
// R17: Explicit operand faults raised when access made.
// R18: Implicit accesses raise no fault or breakpoint.
// R19: Explicit operands come from registers two to four.
// R20: Owner page cached on add, dropped on remove.
// R21: Thread and frame pages cached at entry, flushed.
// R22: Only translated-clean addresses are cached.
// R23: Outside accesses to pool read ones, drop writes.
module enclave_access_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [eac_pkg::BUS_AW-1:0] busAddr,
    input wire logic [eac_pkg::BUS_DW-1:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output wire logic [eac_pkg::BUS_DW-1:0] busRdata,
    // Access request from fetch and load/store
    input wire logic accValid,
    input wire eac_pkg::eac_acc_e accKind,
    input wire logic [eac_pkg::AW-1:0] accAddr,
    input wire logic [2:0] accLen,
    input wire logic accExplicit,
    input wire logic accImplicit,
    input wire logic accSegFault,
    input wire logic accXlatFault,
    input wire logic accPoolHit,
    input wire logic [eac_pkg::IDX_W-1:0] accPoolIdx,
    input wire eac_pkg::eac_ptype_e pageType,
    input wire logic [2:0] pagePerm,
    input wire logic [2:0] pageState,
    input wire logic [eac_pkg::PW-1:0] pageLinPage,
    // Leaf operations
    input wire logic leafValid,
    input wire eac_pkg::eac_leaf_e leafOp,
    input wire logic [eac_pkg::PW-1:0] leafCtrlPa,
    input wire logic [eac_pkg::PW-1:0] leafThreadPa,
    input wire logic [eac_pkg::PW-1:0] leafFramePa,
    input wire logic leafXlatOk,
    input wire logic [eac_pkg::IDX_W-1:0] leafPoolIdx,
    input wire logic [3:0][eac_pkg::AW-1:0] segBase,
    input wire logic [3:0] segUsable,
    input wire logic [eac_pkg::SEL_W-1:0] extFs,
    input wire logic [eac_pkg::SEL_W-1:0] extGs,
    input wire logic [eac_pkg::SEL_W-1:0] threadFs,
    input wire logic [eac_pkg::SEL_W-1:0] threadGs,
    input wire logic [eac_pkg::SEL_W-1:0] frameFsIn,
    input wire logic [eac_pkg::SEL_W-1:0] frameGsIn,
    input wire logic [1:0] opSlot,
    // Access answer
    output wire logic respValid,
    output wire logic respGp,
    output wire logic respPf,
    output wire logic [eac_pkg::EC_W-1:0] respCode,
    output wire logic respSplit,
    output wire logic respOnes,
    output wire logic respDrop,
    output wire logic respQuiet,
    output wire logic respDirect,
    output wire logic respIndirect,
    // Enclave state
    output wire logic inEnclave,
    output wire logic [eac_pkg::SEL_W-1:0] fsOut,
    output wire logic [eac_pkg::SEL_W-1:0] gsOut,
    output wire logic leafGp,
    output wire logic frameStore,
    output wire logic [eac_pkg::SEL_W-1:0] frameFs,
    output wire logic [eac_pkg::SEL_W-1:0] frameGs,
    output wire logic [eac_pkg::PW-1:0] threadPa,
    output wire logic [eac_pkg::PW-1:0] framePa,
    output wire logic paValid,
    output wire logic [1:0] opReg
);
    import eac_pkg::*;

    typedef struct packed {
        logic inEnclave;
        logic [PW-1:0] ctrlPa;
        logic [SEL_W-1:0] savedFs, savedGs, fs, gs;
        logic [PW-1:0] threadPa, framePa;
        logic paValid;
        logic [AW-1:0] rangeBase, rangeLimit;
        logic p1Valid;
        eac_acc_e p1Kind;
        logic p1InLo, p1InHi, p1Pool;
        logic [PW-1:0] p1Page, p1RecPage;
        eac_ptype_e p1Type;
        logic [2:0] p1Perm, p1State;
        logic p1Expl, p1Impl, p1Xlat, p1Seg, p1Encl;
        logic respValid, respGp, respPf;
        logic [EC_W-1:0] respCode;
        logic respSplit, respOnes, respDrop, respQuiet, respDirect, respIndirect;
        logic leafGp, frameStore;
        logic [SEL_W-1:0] frameFs, frameGs;
        logic [1:0] opReg;
        logic [EC_W-1:0] lastCode;
        logic lastGp, lastPf;
        logic [BUS_DW-1:0] rdata;
    } eac_state_s;

    eac_state_s st;
    eac_state_s next_st;

    logic [AW-1:0] accEnd;
    logic accLo;
    logic accHi;
    logic ownValid;
    logic [PW-1:0] ownPa;
    logic memWr;
    logic memWrValid;

    // Inclusive range test against the programmed enclave linear range.
    function automatic logic inRange(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                     input logic [AW-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : inRange

    // Any usable segment with a non-zero base blocks entry.
    function automatic logic segBad(input logic [3:0][AW-1:0] b, input logic [3:0] u);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            bad = bad | (u[i] && (b[i] != '0));
        end
        return bad;
    endfunction : segBad

    // Page fault error code; the enclave bit marks faults found by this checker.
    function automatic logic [EC_W-1:0] pfCode(input eac_acc_e k, input logic encl);
        logic [EC_W-1:0] c;
        c = '0;
        c[EC_PRESENT_BIT] = 1'b1;
        c[EC_WRITE_BIT] = (k == ACC_WRITE);
        c[EC_FETCH_BIT] = (k == ACC_FETCH);
        c[EC_ENCL_BIT] = encl;
        return c;
    endfunction : pfCode

    // Permission needed by each access kind.
    function automatic logic permOk(input eac_acc_e k, input logic [2:0] p);
        return (k == ACC_WRITE) ? p[PERM_W] : (k == ACC_FETCH) ? p[PERM_X] : p[PERM_R];
    endfunction : permOk

    // Owner cache, read in the request cycle so stage one sees it.
    eac_owner_mem u_owner (
        .clk(clk),
        .resetn(resetn),
        .wrEn(memWr),
        .wrIdx(leafPoolIdx),
        .wrValid(memWrValid),
        .wrPa(leafCtrlPa),
        .rdIdx(accPoolIdx),
        .rdValid(ownValid),
        .rdPa(ownPa)
    );

    // Last byte of the access and where each end falls.
    assign accEnd = accAddr + AW'(accLen);
    assign accLo = inRange(accAddr, st.rangeBase, st.rangeLimit);
    assign accHi = inRange(accEnd, st.rangeBase, st.rangeLimit);

    // Next state: capture, judge, leaf flows and register port.
    always_comb begin
        logic direct;
        logic fetchOut;
        logic gp;
        logic dirBad;
        logic pf;
        next_st = st;
        memWr = 1'b0;
        memWrValid = 1'b0;
        next_st.respValid = 1'b0;
        next_st.respGp = 1'b0;
        next_st.respPf = 1'b0;
        next_st.respCode = '0;
        next_st.respSplit = 1'b0;
        next_st.respOnes = 1'b0;
        next_st.respDrop = 1'b0;
        next_st.respQuiet = 1'b0;
        next_st.respDirect = 1'b0;
        next_st.respIndirect = 1'b0;
        next_st.leafGp = 1'b0;
        next_st.frameStore = 1'b0;
        next_st.rdata = '0;
        next_st.opReg = 2'(OPREG_FIRST + opSlot - 2'h1); // R19

        // Stage zero: the inside part's page and map entry travel with the request.
        next_st.p1Valid = accValid;
        next_st.p1Kind = accKind;
        next_st.p1InLo = accLo;
        next_st.p1InHi = accHi;
        next_st.p1Pool = accPoolHit;
        next_st.p1Page = accLo ? accAddr[AW-1:PG_LSB] : accEnd[AW-1:PG_LSB]; // R15
        next_st.p1RecPage = pageLinPage;
        next_st.p1Type = pageType;
        next_st.p1Perm = pagePerm;
        next_st.p1State = pageState;
        next_st.p1Expl = accExplicit;
        next_st.p1Impl = accImplicit;
        next_st.p1Xlat = accXlatFault;
        next_st.p1Seg = accSegFault;
        next_st.p1Encl = st.inEnclave;

        // Stage one: leaf accesses are never direct, whatever the address.
        direct = st.p1Encl && (st.p1InLo || st.p1InHi) && !st.p1Expl && !st.p1Impl; // R2
        fetchOut = st.p1Encl && (st.p1Kind == ACC_FETCH) && !(st.p1InLo && st.p1InHi)
                   && !st.p1Expl && !st.p1Impl; // R3 R16
        gp = !st.p1Impl && (st.p1Seg || fetchOut); // R10 R18
        dirBad = direct && (!st.p1Pool
                 || (st.p1RecPage != st.p1Page) // R4
                 || !ownValid || (ownPa != st.ctrlPa) // R5 R6
                 || !permOk(st.p1Kind, st.p1Perm) // R7
                 || (st.p1Type inside {PT_CONTROL, PT_THREAD, PT_VERSION, PT_TRIMMED}) // R8
                 || st.p1State[ST_BLOCKED] || st.p1State[ST_PENDING]
                 || st.p1State[ST_MODIFIED]); // R9
        pf = !gp && !st.p1Impl && (dirBad || (st.p1Expl && st.p1Xlat)); // R17 R18
        if (st.p1Valid) begin
            next_st.respValid = 1'b1;
            next_st.respGp = gp;
            next_st.respPf = pf;
            next_st.respCode = gp ? GP_CODE : (pf ? pfCode(st.p1Kind, dirBad) : '0);
            next_st.respSplit = direct && (st.p1Kind != ACC_FETCH)
                                && (st.p1InLo != st.p1InHi); // R15
            next_st.respQuiet = st.p1Impl; // R18 R22
            next_st.respDirect = direct;
            next_st.respIndirect = (st.p1Expl || st.p1Impl) && st.p1Pool; // R2
            // Undefined outside use of the pool is made harmless, never revealing.
            if (!st.p1Encl && st.p1Pool && !st.p1Expl && !st.p1Impl && !gp) begin
                next_st.respOnes = (st.p1Kind != ACC_WRITE); // R23
                next_st.respDrop = (st.p1Kind == ACC_WRITE); // R23
            end
            if (gp || pf) begin
                next_st.lastGp = gp;
                next_st.lastPf = pf;
                next_st.lastCode = gp ? GP_CODE : pfCode(st.p1Kind, dirBad);
            end
        end

        // Leaf flows; entry while inside and exit while outside are ignored.
        if (leafValid) begin
            unique case (leafOp)
                LEAF_NONE: begin
                end
                LEAF_ENTER, LEAF_RESUME: begin
                    if (!st.inEnclave) begin
                        if (segBad(segBase, segUsable)) begin
                            next_st.leafGp = 1'b1; // R11
                        end else if (leafXlatOk) begin
                            next_st.inEnclave = 1'b1; // R1
                            next_st.savedFs = extFs; // R12
                            next_st.savedGs = extGs;
                            next_st.fs = (leafOp == LEAF_ENTER) ? threadFs : frameFsIn; // R12 R14
                            next_st.gs = (leafOp == LEAF_ENTER) ? threadGs : frameGsIn;
                            next_st.ctrlPa = leafCtrlPa;
                            next_st.threadPa = leafThreadPa; // R21 R22
                            next_st.framePa = leafFramePa;
                            next_st.paValid = 1'b1;
                        end
                    end
                end
                LEAF_EXIT, LEAF_ASYNC_EXIT: begin
                    if (st.inEnclave) begin
                        next_st.inEnclave = 1'b0; // R1
                        next_st.fs = st.savedFs; // R13
                        next_st.gs = st.savedGs;
                        next_st.paValid = 1'b0; // R21
                        next_st.threadPa = '0;
                        next_st.framePa = '0;
                        if (leafOp == LEAF_ASYNC_EXIT) begin
                            next_st.frameStore = 1'b1; // R14
                            next_st.frameFs = st.fs;
                            next_st.frameGs = st.gs;
                        end
                    end
                end
                LEAF_ADD, LEAF_AUGMENT: begin
                    // A failed translation leaves the binding untouched.
                    memWr = leafXlatOk; // R20 R22
                    memWrValid = 1'b1;
                end
                LEAF_REMOVE: begin
                    memWr = 1'b1; // R20
                    memWrValid = 1'b0;
                end
            endcase
        end

        // Register port: writes steer the range, reads show state.
        if (busWr) begin
            if (busAddr == REG_RANGE_BASE) begin
                next_st.rangeBase = busWdata;
            end else if (busAddr == REG_RANGE_LIMIT) begin
                next_st.rangeLimit = busWdata;
            end
        end
        if (busRd) begin
            if (busAddr == REG_RANGE_BASE) begin
                next_st.rdata = st.rangeBase;
            end else if (busAddr == REG_RANGE_LIMIT) begin
                next_st.rdata = st.rangeLimit;
            end else if (busAddr == REG_STATUS) begin
                next_st.rdata[STAT_ENC_BIT] = st.inEnclave;
                next_st.rdata[STAT_PAV_BIT] = st.paValid;
                next_st.rdata[STAT_GP_BIT] = st.lastGp;
                next_st.rdata[STAT_PF_BIT] = st.lastPf;
            end else if (busAddr == REG_LAST_CODE) begin
                next_st.rdata[EC_W-1:0] = st.lastCode;
            end else if (busAddr == REG_CTRL_PA) begin
                next_st.rdata[PW-1:0] = st.ctrlPa;
            end
        end
    end

    // Single state register; the range base and limit get their own reset values.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
            st.rangeBase <= RANGE_BASE_RST;
            st.rangeLimit <= RANGE_LIMIT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a state field.
    assign busRdata = st.rdata;
    assign respValid = st.respValid;
    assign respGp = st.respGp;
    assign respPf = st.respPf;
    assign respCode = st.respCode;
    assign respSplit = st.respSplit;
    assign respOnes = st.respOnes;
    assign respDrop = st.respDrop;
    assign respQuiet = st.respQuiet;
    assign respDirect = st.respDirect;
    assign respIndirect = st.respIndirect;
    assign inEnclave = st.inEnclave;
    assign fsOut = st.fs;
    assign gsOut = st.gs;
    assign leafGp = st.leafGp;
    assign frameStore = st.frameStore;
    assign frameFs = st.frameFs;
    assign frameGs = st.frameGs;
    assign threadPa = st.threadPa;
    assign framePa = st.framePa;
    assign paValid = st.paValid;
    assign opReg = st.opReg;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Entry and exit only through their leaves.
    a_entry_by_leaf: assert property ($rose(st.inEnclave) |-> $past(leafValid) // R1
        && ($past(leafOp) inside {LEAF_ENTER, LEAF_RESUME}))
        else $error("enclave entered without enter or resume");
    a_exit_by_leaf: assert property ($fell(st.inEnclave) |-> $past(leafValid) // R1
        && ($past(leafOp) inside {LEAF_EXIT, LEAF_ASYNC_EXIT}))
        else $error("enclave left without exit");
    // Fetch leaving the range faults two cycles on.
    a_fetch_out_gp: assert property (accValid && st.inEnclave && accKind == ACC_FETCH // R3
        && !(accLo && accHi) && !accExplicit && !accImplicit
        |-> ##2 respValid && respGp && respCode == GP_CODE)
        else $error("outside fetch not faulted");
    // Wrong linear binding is an enclave page fault.
    a_binding_pf: assert property (accValid && st.inEnclave && accLo && accHi // R4
        && !accSegFault && !accExplicit && !accImplicit && pageLinPage != accAddr[AW-1:PG_LSB]
        |-> ##2 respPf && respCode[EC_ENCL_BIT])
        else $error("binding mismatch not faulted");
    a_write_perm: assert property (accValid && st.inEnclave && accLo && accHi // R7
        && accKind == ACC_WRITE && !pagePerm[PERM_W] && !accSegFault && !accExplicit
        && !accImplicit |-> ##2 respPf && respCode[EC_WRITE_BIT] && respCode[EC_ENCL_BIT])
        else $error("write without permission passed");
    a_page_state: assert property (accValid && st.inEnclave && accLo && !accSegFault // R9
        && !accExplicit && !accImplicit && (pageState != 3'h0) && accHi |-> ##2 respPf)
        else $error("blocked page passed");
    a_seg_base: assert property (leafValid && leafOp == LEAF_ENTER && !st.inEnclave // R11
        && segBad(segBase, segUsable) |=> leafGp && !inEnclave)
        else $error("non-zero segment base entered");
    a_restore_segs: assert property (leafValid && leafOp == LEAF_EXIT && st.inEnclave // R13
        |=> fsOut == $past(st.savedFs) && gsOut == $past(st.savedGs))
        else $error("thread segments not restored");
    a_implicit_quiet: assert property (accValid && accImplicit // R18
        |-> ##2 respQuiet && !respGp && !respPf)
        else $error("implicit access faulted");
    a_cache_flush: assert property ($fell(st.inEnclave) |-> !paValid) // R21
        else $error("cached pages survive exit");
    a_outside_ones: assert property (accValid && !st.inEnclave && accPoolHit // R23
        && accKind == ACC_READ && !accSegFault && !accExplicit && !accImplicit
        |-> ##2 respOnes && !respDrop)
        else $error("outside read of pool not masked");
endmodule : enclave_access_checker

//--- testbench/eac_core_model.sv
// Core-side model: translation lookup of the page that holds an access.
`timescale 1ns/1ps
module eac_core_model (
    // Access and range
    input wire logic [eac_pkg::AW-1:0] addr,
    input wire logic [eac_pkg::AW-1:0] lo,
    input wire logic [eac_pkg::AW-1:0] hi,
    // Attributes chosen by the bench
    input wire eac_pkg::eac_ptype_e attrType,
    input wire logic [2:0] attrPerm,
    input wire logic [2:0] attrState,
    input wire logic linSkew,
    // Answers
    output wire logic poolHit,
    output wire logic [eac_pkg::IDX_W-1:0] poolIdx,
    output wire eac_pkg::eac_ptype_e pageType,
    output wire logic [2:0] pagePerm,
    output wire logic [2:0] pageState,
    output wire logic [eac_pkg::PW-1:0] linPage
);
    import eac_pkg::*;
    // Pool pages alias the range; a skew reports a wrong recorded page.
    assign poolHit = addr >= lo && addr <= hi;
    assign poolIdx = addr[PG_LSB+:IDX_W];
    assign pageType = attrType;
    assign pagePerm = attrPerm;
    assign pageState = attrState;
    assign linPage = addr[AW-1:PG_LSB] + PW'(linSkew);
endmodule : eac_core_model

//--- testbench/enclave_access_checker_tb_top.sv
// Self-checking bench for the enclave access checker.
`timescale 1ns/1ps
module enclave_access_checker_tb_top;
    import eac_pkg::*;
    localparam logic [31:0] BASE = 32'h0001_0000;
    logic clk = 0, resetn = 0, busWr = 0, busRd = 0, accValid = 0, leafValid = 0, skew = 0;
    logic [7:0] busAddr = 0;
    logic [31:0] busWdata = 0, accAddr = 0, rdv;
    logic [2:0] perm = 0, state = 0;
    logic [3:0][31:0] segBase = 0;
    logic [15:0] extFs = 16'h0011, thFs = 16'h0022, frFs = 16'h0033;
    eac_acc_e accKind = ACC_READ;
    eac_leaf_e leafOp = LEAF_NONE;
    eac_ptype_e ptype = PT_REGULAR, pt;
    logic [31:0] busRdata;
    logic rV, rGp, rPf, rOnes, inEnc, lGp, fStore, paV, hit, pf, im = 0, sf = 0, xo = 1;
    logic [15:0] rCode, fsOut, frameFs;
    logic [19:0] thPa, lin;
    logic [3:0] idx;
    logic [2:0] pPerm, pState;
    int err_total = 0, num_checks = 0;
    eac_core_model core_u (.addr(accAddr), .lo(BASE), .hi(BASE + 32'hffff), .attrType(ptype),
        .attrPerm(perm), .attrState(state), .linSkew(skew), .poolHit(hit), .poolIdx(idx),
        .pageType(pt), .pagePerm(pPerm), .pageState(pState), .linPage(lin));
    enclave_access_checker dut_u (.clk(clk), .resetn(resetn), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
        .accValid(accValid), .accKind(accKind), .accAddr(accAddr), .accLen(accAddr[2:0]),
        .accExplicit(1'b0), .accImplicit(im), .accSegFault(sf), .accXlatFault(skew & ~hit),
        .accPoolHit(hit), .accPoolIdx(idx), .pageType(pt), .pagePerm(pPerm),
        .pageState(pState), .pageLinPage(lin), .leafValid(leafValid), .leafOp(leafOp),
        .leafCtrlPa(20'h12345), .leafThreadPa(20'h00abc), .leafFramePa(20'h00abd),
        .leafXlatOk(xo), .leafPoolIdx(idx), .segBase(segBase), .segUsable(4'hf),
        .extFs(extFs), .extGs(extFs), .threadFs(thFs), .threadGs(thFs), .frameFsIn(frFs),
        .frameGsIn(frFs), .opSlot(accKind), .respValid(rV), .respGp(rGp), .respPf(rPf),
        .respCode(rCode), .respSplit(), .respOnes(rOnes), .respDrop(), .respQuiet(),
        .respDirect(), .respIndirect(), .inEnclave(inEnc), .fsOut(fsOut), .gsOut(),
        .leafGp(lGp), .frameStore(fStore), .frameFs(frameFs), .frameGs(), .threadPa(thPa),
        .framePa(), .paValid(paV), .opReg());
    // Free-running core clock.
    initial forever #4 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One strobe cycle; read data is caught in the cycle after it.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busWr <= w;
        busRd <= !w;
        busAddr <= a;
        busWdata <= d;
        @(posedge clk);
        busWr <= 1'b0;
        busRd <= 1'b0;
        #1 rdv = busRdata;
    endtask : bus
    task automatic leaf(input eac_leaf_e op);
        @(posedge clk);
        leafValid <= 1'b1;
        leafOp <= op;
        @(posedge clk);
        leafValid <= 1'b0;
        #1;
    endtask : leaf
    // The answer lands two cycles after the request edge.
    task automatic acc(input eac_acc_e k, input logic [31:0] a);
        @(posedge clk);
        accValid <= 1'b1;
        accKind <= k;
        accAddr <= a;
        @(posedge clk);
        accValid <= 1'b0;
        @(posedge clk);
        #1 chk("respValid", rV, 1);
    endtask : acc
    function automatic logic exp_pf(input eac_acc_e k);
        return !perm[k == ACC_WRITE ? PERM_W : k == ACC_FETCH ? PERM_X : PERM_R]
            || ptype != PT_REGULAR || state != 0 || skew;
    endfunction : exp_pf
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Watchdog: the tests need well under two thousand cycles.
    initial begin
        #(2000 * 8);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(82));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        bus(1, REG_RANGE_BASE, BASE);
        bus(1, REG_RANGE_LIMIT, BASE + 32'hffff);
        bus(0, REG_RANGE_LIMIT, 0);
        chk("limit", rdv, BASE + 32'hffff);
        bus(0, 8'h40, 0);
        chk("unmapped", rdv, 0);
        leaf(LEAF_ADD);
        segBase[1] <= 32'h0000_1000;
        leaf(LEAF_ENTER);
        chk("leafGp", lGp, 1);
        chk("inEnclave", inEnc, 0);
        segBase <= '0;
        leaf(LEAF_ENTER);
        chk("inEnclave", inEnc, 1);
        chk("fsOut", fsOut, thFs);
        chk("threadPa", {paV, thPa}, 21'h100abc);
        $display("entry test done");
        repeat (24) begin
            ptype <= eac_ptype_e'($urandom_range(4) * ($urandom_range(1)));
            perm <= 3'($urandom);
            state <= ($urandom_range(3) == 0) ? 3'($urandom) : 3'h0;
            skew <= ($urandom_range(3) == 0);
            acc(eac_acc_e'($urandom_range(2)), BASE + ($urandom & 32'hff8));
            pf = exp_pf(accKind);
            chk("respPf", rPf, pf);
            chk("enclave bit", rCode[EC_ENCL_BIT], pf);
        end
        {ptype, perm, state, skew} <= {PT_REGULAR, 3'h7, 3'h0, 1'b0};
        acc(ACC_FETCH, 32'h0005_0000);
        chk("fetch gp", {rGp, rCode}, 17'h10000);
        $display("access test done");
        leaf(LEAF_ASYNC_EXIT);
        chk("frame", {fStore, frameFs}, {1'b1, thFs});
        chk("restore", {inEnc, paV, fsOut}, {2'b00, extFs});
        leaf(LEAF_RESUME);
        chk("resume fs", fsOut, frFs);
        leaf(LEAF_EXIT);
        chk("exit fs", fsOut, extFs);
        acc(ACC_READ, BASE);
        chk("ones", rOnes, 1);
        leaf(LEAF_REMOVE);
        leaf(LEAF_ENTER);
        acc(ACC_READ, BASE);
        chk("removed pf", rPf, 1);
        {im, sf} <= 2'b11;
        acc(ACC_WRITE, BASE);
        chk("implicit", {rGp, rPf}, 0);
        $display("exit test done");
        conclude();
    end
endmodule : enclave_access_checker_tb_top
